//--- rtl/aur_pkg.sv
// Constants, register map and state encodings for the asynchronous receiver/transmitter.
// Assumes a single 20 MHz bus clock and an AXI4-Lite master with 32-bit data.
package aur_pkg;
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
	localparam int unsigned OVERSAMPLE    = 16;
	localparam int unsigned BAUD_DEFAULT  = 9600;
	localparam int unsigned DIV_RAW       = CLK_HZ / (OVERSAMPLE * BAUD_DEFAULT) - 1;
	localparam logic [15:0] DIV_DEFAULT   = 16'(DIV_RAW);

	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_TXDATA = 8'h04;
	localparam logic [7:0] ADDR_RXDATA = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_DIV    = 8'h10;

	// Control register fields.
	localparam int unsigned CTRL_LEN_LO = 0;
	localparam int unsigned CTRL_LEN_HI = 1;
	localparam int unsigned CTRL_STOP2  = 2;
	localparam int unsigned CTRL_NOPAR  = 3;
	localparam int unsigned CTRL_EVEN   = 4;
	localparam int unsigned CTRL_W      = 5;

	// Command bits written at the status offset.
	localparam int unsigned CMD_CLR_DAV = 0;
	localparam int unsigned CMD_XRESET  = 1;

	// Status bit positions.
	localparam int unsigned ST_DAV  = 0;
	localparam int unsigned ST_PE   = 1;
	localparam int unsigned ST_FE   = 2;
	localparam int unsigned ST_OE   = 3;
	localparam int unsigned ST_THRE = 4;
	localparam int unsigned ST_EOC  = 5;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [3:0] LEN_BASE     = 4'h5;
	localparam logic [3:0] LEN_MAX      = 4'h8;
	localparam logic [3:0] RX_MID_TICK  = 4'h7;
	localparam logic [3:0] BIT_LAST     = 4'hF;
	localparam logic [4:0] STOP1_LAST   = 5'h0F;
	localparam logic [4:0] STOP15_LAST  = 5'h17;
	localparam logic [4:0] STOP2_LAST   = 5'h1F;

	typedef enum logic [2:0] {
		TX_IDLE   = 3'b000,
		TX_START  = 3'b001,
		TX_DATA   = 3'b010,
		TX_PARITY = 3'b011,
		TX_STOP   = 3'b100
	} aur_tx_state_t;

	typedef enum logic [2:0] {
		RX_IDLE   = 3'b000,
		RX_START  = 3'b001,
		RX_DATA   = 3'b010,
		RX_PARITY = 3'b011,
		RX_STOP   = 3'b100
	} aur_rx_state_t;
endpackage

//--- rtl/aur_uart.sv
// Full-duplex asynchronous receiver/transmitter with an AXI4-Lite register slave.
// Assumes serial_in is already synchronous to aclk; the 16x bit clock is a tick from aclk.
// Behaviour
// - Reset drives holding-empty, end-of-char, serial output high.
// - Reset holds receive data-available low.
// - Data strobe fills holding register, clears holding-empty.
// - Empty shifter takes waiting character, line and EOC drop.
// - Frame is start, data, optional parity, stop bits.
// - End-of-char rises after last stop bit time.
// - New frame starts only with a waiting character.
// - Falling edge checked low eight ticks later.
// - High at centre sample abandons the start bit.
// - Centre count begins at the next tick.
// - Parity and stop mismatches set error flags.
// - No-parity mode keeps parity error low.
// - Overrun set when previous data-available not yet cleared.
// - Shifter free for next character once available.
// - No-parity omits parity bit both directions.
// - Stop select one or two; five-bit gives one and half.
// - Length select gives five to eight data bits.
// - Parity sense low odd, high even.
module aur_uart #(
	parameter logic [15:0] DIV_INIT = aur_pkg::DIV_DEFAULT
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [aur_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [aur_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       serial_in,
	output logic                            serial_out
);
	typedef struct packed {
		logic                       aw_got;
		logic [aur_pkg::ADDR_W-1:0] aw_addr;
		logic                       w_got;
		logic [31:0]                w_data;
		logic [3:0]                 w_strb;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       rvalid;
		logic [31:0]                rdata;
		logic [1:0]                 rresp;
		logic [aur_pkg::CTRL_W-1:0] ctrl;
		logic [15:0]                divisor;
		logic [15:0]                div_cnt;
		aur_pkg::aur_tx_state_t     tx_state;
		logic [7:0]                 tx_hold;
		logic                       tx_holding_empty;
		logic [7:0]                 tx_shift;
		logic [3:0]                 tx_bit;
		logic [4:0]                 tx_sub;
		logic                       tx_par;
		logic                       sout;
		logic                       eoc;
		aur_pkg::aur_rx_state_t     rx_state;
		logic                       rx_prev;
		logic [7:0]                 rx_shift;
		logic [3:0]                 rx_bit;
		logic [3:0]                 rx_sub;
		logic                       rx_par_bad;
		logic [7:0]                 rx_hold;
		logic                       rx_data_available;
		logic                       parity_error_flag;
		logic                       framing_error_flag;
		logic                       overrun_flag;
	} aur_state_t;

	aur_state_t st_reg;
	aur_state_t st_next;

	function automatic logic [3:0] char_len(input logic [aur_pkg::CTRL_W-1:0] c);
		char_len = aur_pkg::LEN_BASE + {2'b00, c[aur_pkg::CTRL_LEN_HI:aur_pkg::CTRL_LEN_LO]};
	endfunction

	function automatic logic par_bit(input logic [7:0] d, input logic [aur_pkg::CTRL_W-1:0] c);
		logic [7:0] mask;
		mask = 8'hFF >> (aur_pkg::LEN_MAX - char_len(c));
		par_bit = (^(d & mask)) ~^ c[aur_pkg::CTRL_EVEN];
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction

	always_comb begin
		logic                       tick;
		logic                       do_load;
		logic                       do_clear;
		logic                       do_xreset;
		logic                       np;
		logic [3:0]                 len;
		logic [7:0]                 rx_aligned;
		logic [4:0]                 stop_last;
		logic [aur_pkg::ADDR_W-1:0] wa;
		logic [aur_pkg::ADDR_W-1:0] ra;
		logic [31:0]                m;
		st_next    = st_reg;
		do_load    = 1'b0;
		do_clear   = 1'b0;
		do_xreset  = 1'b0;
		m          = '0;
		tick       = 1'b0;
		stop_last  = aur_pkg::STOP1_LAST;
		np         = st_reg.ctrl[aur_pkg::CTRL_NOPAR];
		len        = char_len(st_reg.ctrl);
		rx_aligned = st_reg.rx_shift >> (aur_pkg::LEN_MAX - len);
		wa         = {st_reg.aw_addr[aur_pkg::ADDR_W-1:2], 2'b00};
		ra         = {s_axi_araddr[aur_pkg::ADDR_W-1:2], 2'b00};
		if (st_reg.ctrl[aur_pkg::CTRL_STOP2] == 1'b0) begin
			stop_last = aur_pkg::STOP1_LAST;
		end else if (len == aur_pkg::LEN_BASE) begin
			stop_last = aur_pkg::STOP15_LAST;
		end else begin
			stop_last = aur_pkg::STOP2_LAST;
		end

		// Divider from aclk down to the sixteen-times bit clock.
		tick = (st_reg.div_cnt == '0);
		st_next.div_cnt = tick ? st_reg.divisor : st_reg.div_cnt - 16'h0001;

		// Write channel: address and data may arrive in either order.
		if (s_axi_awvalid && s_axi_awready) begin
			st_next.aw_got  = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_next.w_got  = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
			st_next.aw_got = 1'b0;
			st_next.w_got  = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp  = aur_pkg::RESP_OKAY;
			m = merge('0, st_reg.w_data, st_reg.w_strb);
			case (wa)
				aur_pkg::ADDR_CTRL: begin
					if (st_reg.w_strb[0]) begin
						st_next.ctrl = m[aur_pkg::CTRL_W-1:0];
					end
				end
				aur_pkg::ADDR_TXDATA: do_load = st_reg.w_strb[0];
				aur_pkg::ADDR_RXDATA: st_next.bresp = aur_pkg::RESP_OKAY;
				aur_pkg::ADDR_STATUS: begin
					do_clear  = st_reg.w_strb[0] && m[aur_pkg::CMD_CLR_DAV];
					do_xreset = st_reg.w_strb[0] && m[aur_pkg::CMD_XRESET];
				end
				aur_pkg::ADDR_DIV: st_next.divisor = 16'(merge({16'h0000, st_reg.divisor},
					st_reg.w_data, st_reg.w_strb));
				default: st_next.bresp = aur_pkg::RESP_SLVERR;
			endcase
		end

		// Read channel: one read in flight, answered the cycle after it is taken.
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			st_next.rvalid = 1'b1;
			st_next.rresp  = aur_pkg::RESP_OKAY;
			st_next.rdata  = '0;
			case (ra)
				aur_pkg::ADDR_CTRL:   st_next.rdata[aur_pkg::CTRL_W-1:0] = st_reg.ctrl;
				aur_pkg::ADDR_TXDATA: st_next.rdata[7:0] = st_reg.tx_hold;
				aur_pkg::ADDR_RXDATA: st_next.rdata[7:0] = st_reg.rx_hold;
				aur_pkg::ADDR_STATUS: begin
					st_next.rdata[aur_pkg::ST_DAV]  = st_reg.rx_data_available;
					st_next.rdata[aur_pkg::ST_PE]   = st_reg.parity_error_flag;
					st_next.rdata[aur_pkg::ST_FE]   = st_reg.framing_error_flag;
					st_next.rdata[aur_pkg::ST_OE]   = st_reg.overrun_flag;
					st_next.rdata[aur_pkg::ST_THRE] = st_reg.tx_holding_empty;
					st_next.rdata[aur_pkg::ST_EOC]  = st_reg.eoc;
				end
				aur_pkg::ADDR_DIV:    st_next.rdata[15:0] = st_reg.divisor;
				default:              st_next.rresp = aur_pkg::RESP_SLVERR;
			endcase
		end

		// Transmitter.
		case (st_reg.tx_state)
			aur_pkg::TX_IDLE: begin
				if (!st_reg.tx_holding_empty) begin
					st_next.tx_shift         = st_reg.tx_hold;
					st_next.tx_par           = par_bit(st_reg.tx_hold, st_reg.ctrl);
					st_next.tx_holding_empty = 1'b1;
					st_next.sout             = 1'b0;
					st_next.eoc              = 1'b0;
					st_next.tx_sub           = '0;
					st_next.tx_state         = aur_pkg::TX_START;
				end
			end
			aur_pkg::TX_START: begin
				if (tick) begin
					st_next.tx_sub = st_reg.tx_sub + 5'h01;
					if (st_reg.tx_sub[3:0] == aur_pkg::BIT_LAST) begin
						st_next.tx_sub   = '0;
						st_next.tx_bit   = '0;
						st_next.sout     = st_reg.tx_shift[0];
						st_next.tx_state = aur_pkg::TX_DATA;
					end
				end
			end
			aur_pkg::TX_DATA: begin
				if (tick) begin
					st_next.tx_sub = st_reg.tx_sub + 5'h01;
					if (st_reg.tx_sub[3:0] == aur_pkg::BIT_LAST) begin
						st_next.tx_sub = '0;
						if (st_reg.tx_bit == len - 4'h1) begin
							st_next.sout     = np ? 1'b1 : st_reg.tx_par;
							st_next.tx_state = np ? aur_pkg::TX_STOP : aur_pkg::TX_PARITY;
						end else begin
							st_next.tx_bit   = st_reg.tx_bit + 4'h1;
							st_next.tx_shift = st_reg.tx_shift >> 1;
							st_next.sout     = st_reg.tx_shift[1];
						end
					end
				end
			end
			aur_pkg::TX_PARITY: begin
				if (tick) begin
					st_next.tx_sub = st_reg.tx_sub + 5'h01;
					if (st_reg.tx_sub[3:0] == aur_pkg::BIT_LAST) begin
						st_next.tx_sub   = '0;
						st_next.sout     = 1'b1;
						st_next.tx_state = aur_pkg::TX_STOP;
					end
				end
			end
			aur_pkg::TX_STOP: begin
				if (tick) begin
					st_next.tx_sub = st_reg.tx_sub + 5'h01;
					if (st_reg.tx_sub == stop_last) begin
						st_next.eoc      = 1'b1;
						st_next.tx_state = aur_pkg::TX_IDLE;
					end
				end
			end
			default: st_next.tx_state = aur_pkg::TX_IDLE;
		endcase
		// A new character written while the old one moves to the shifter is kept.
		if (do_load) begin
			st_next.tx_hold          = m[7:0];
			st_next.tx_holding_empty = 1'b0;
		end

		// Receiver.  A clear strobe is applied first so a character landing in the
		// same cycle still raises data-available.
		if (do_clear) begin
			st_next.rx_data_available = 1'b0;
		end
		st_next.rx_prev = serial_in;
		case (st_reg.rx_state)
			aur_pkg::RX_IDLE: begin
				if (st_reg.rx_prev && !serial_in) begin
					st_next.rx_sub   = '0;
					st_next.rx_state = aur_pkg::RX_START;
				end
			end
			aur_pkg::RX_START: begin
				if (tick) begin
					st_next.rx_sub = st_reg.rx_sub + 4'h1;
					if (st_reg.rx_sub == aur_pkg::RX_MID_TICK) begin
						st_next.rx_sub     = '0;
						st_next.rx_bit     = '0;
						st_next.rx_par_bad = 1'b0;
						st_next.rx_state   = serial_in ? aur_pkg::RX_IDLE
							: aur_pkg::RX_DATA;
					end
				end
			end
			aur_pkg::RX_DATA: begin
				if (tick) begin
					st_next.rx_sub = st_reg.rx_sub + 4'h1;
					if (st_reg.rx_sub == aur_pkg::BIT_LAST) begin
						st_next.rx_sub   = '0;
						st_next.rx_shift = {serial_in, st_reg.rx_shift[7:1]};
						st_next.rx_bit   = st_reg.rx_bit + 4'h1;
						if (st_reg.rx_bit == len - 4'h1) begin
							st_next.rx_state = np ? aur_pkg::RX_STOP
								: aur_pkg::RX_PARITY;
						end
					end
				end
			end
			aur_pkg::RX_PARITY: begin
				if (tick) begin
					st_next.rx_sub = st_reg.rx_sub + 4'h1;
					if (st_reg.rx_sub == aur_pkg::BIT_LAST) begin
						st_next.rx_sub     = '0;
						st_next.rx_par_bad = serial_in != par_bit(rx_aligned, st_reg.ctrl);
						st_next.rx_state   = aur_pkg::RX_STOP;
					end
				end
			end
			aur_pkg::RX_STOP: begin
				if (tick) begin
					st_next.rx_sub = st_reg.rx_sub + 4'h1;
					if (st_reg.rx_sub == aur_pkg::BIT_LAST) begin
						// Data and all flags land on the same edge as data-available.
						st_next.rx_hold            = rx_aligned;
						st_next.parity_error_flag  = st_reg.rx_par_bad && !np;
						st_next.framing_error_flag = !serial_in;
						st_next.overrun_flag       = st_reg.rx_data_available;
						st_next.rx_data_available  = 1'b1;
						st_next.rx_state           = aur_pkg::RX_IDLE;
					end
				end
			end
			default: st_next.rx_state = aur_pkg::RX_IDLE;
		endcase

		if (do_xreset) begin
			st_next.tx_state           = aur_pkg::TX_IDLE;
			st_next.tx_holding_empty   = 1'b1;
			st_next.eoc                = 1'b1;
			st_next.sout               = 1'b1;
			st_next.rx_state           = aur_pkg::RX_IDLE;
			st_next.rx_hold            = '0;
			st_next.rx_data_available  = 1'b0;
			st_next.parity_error_flag  = 1'b0;
			st_next.framing_error_flag = 1'b0;
			st_next.overrun_flag       = 1'b0;
		end

		if (!aresetn) begin
			st_next                  = '0;
			st_next.divisor          = DIV_INIT;
			st_next.div_cnt          = DIV_INIT;
			st_next.tx_holding_empty = 1'b1;
			st_next.eoc              = 1'b1;
			st_next.sout             = 1'b1;
			st_next.rx_prev          = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		st_reg <= st_next;
	end

	assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
	assign s_axi_wready  = !st_reg.w_got && !st_reg.bvalid;
	assign s_axi_bvalid  = st_reg.bvalid;
	assign s_axi_bresp   = st_reg.bresp;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_rvalid  = st_reg.rvalid;
	assign s_axi_rdata   = st_reg.rdata;
	assign s_axi_rresp   = st_reg.rresp;
	assign serial_out    = st_reg.sout;
endmodule

//--- bench/aur_props.sv
// Concurrent checks on the ports of the receiver/transmitter.
// Assumes the divisor is 0, so one bit time is sixteen aclk cycles.
module aur_props (
	input wire logic                       aclk,
	input wire logic                       aresetn,
	input wire logic [aur_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic                       s_axi_awvalid,
	input wire logic                       s_axi_awready,
	input wire logic                       s_axi_wvalid,
	input wire logic                       s_axi_wready,
	input wire logic [1:0]                 s_axi_bresp,
	input wire logic                       s_axi_bvalid,
	input wire logic [aur_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic [31:0]                s_axi_rdata,
	input wire logic [1:0]                 s_axi_rresp,
	input wire logic                       s_axi_rvalid,
	input wire logic                       serial_out
);
	logic [7:0] run_reg;
	logic [7:0] run_next;
	logic       prev_reg;
	// The run counter saturates so a long idle line never wraps into a short run.
	always_comb begin
		run_next = (run_reg == 8'hFF) ? run_reg : run_reg + 8'h01;
		if (serial_out != prev_reg) begin
			run_next = 8'h00;
		end
	end
	always_ff @(posedge aclk) begin
		prev_reg <= serial_out;
		run_reg  <= aresetn ? run_next : 8'hFF;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// The response is registered one edge after both halves are held, so it shows two edges on.
	AST_B_AFTER_AW_W: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response missing");
	AST_AW_REFUSED: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data missing");
	AST_AR_REFUSED: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	AST_RD_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h20
		|=> s_axi_rresp == aur_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	AST_WR_UNMAPPED: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h20
		|-> ##[2:4] (s_axi_bvalid && s_axi_bresp == aur_pkg::RESP_SLVERR))
		else $error("unmapped write not refused");
	AST_RD_OKAY: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] <= 6'h04
		|=> s_axi_rresp == aur_pkg::RESP_OKAY) else $error("mapped read refused");
	AST_RESET_IDLE: assert property ($rose(aresetn) |-> serial_out && !s_axi_bvalid
		&& !s_axi_rvalid && s_axi_arready) else $error("outputs not idle after reset");
	AST_BIT_TIME: assert property ($changed(serial_out) |-> run_reg >= 8'h0F)
		else $error("line level shorter than one bit time");
	AST_START_LOW: assert property ($fell(serial_out) |-> !serial_out [*8])
		else $error("start bit cut short");
	COV_WRITE: cover property (s_axi_bvalid && s_axi_bresp == aur_pkg::RESP_OKAY);
	COV_SLVERR: cover property (s_axi_rvalid && s_axi_rresp == aur_pkg::RESP_SLVERR);
	COV_FRAME: cover property ($fell(serial_out));
endmodule

//--- bench/aur_remote_model.sv
// Remote serial device: sends frames on serial_in and samples frames on serial_out.
// Assumes one bit time is sixteen aclk cycles; the line idles marking.
module aur_remote_model (
	input wire logic aclk,
	output logic     serial_in,
	input wire logic serial_out
);
	localparam int BIT = 16;
	initial serial_in = 1'b1;
	task automatic tick(input int c);
		repeat (c) @(posedge aclk);
		#1;
	endtask
	// A stop level of 0 holds the whole stop time low for a framing fault.
	task automatic send(input logic [7:0] d, input int n, input logic pe, input logic pb,
		input int half_stops, input logic stop_lvl);
		@(posedge aclk);
		serial_in <= 1'b0;
		repeat (BIT) @(posedge aclk);
		for (int i = 0; i < n; i++) begin
			serial_in <= d[i];
			repeat (BIT) @(posedge aclk);
		end
		if (pe) begin
			serial_in <= pb;
			repeat (BIT) @(posedge aclk);
		end
		serial_in <= stop_lvl;
		repeat (half_stops * BIT / 2) @(posedge aclk);
		serial_in <= 1'b1;
		repeat (BIT) @(posedge aclk);
	endtask
	// A short low pulse that is high again well before the start-bit centre.
	task automatic glitch(input int low);
		@(posedge aclk);
		serial_in <= 1'b0;
		repeat (low) @(posedge aclk);
		serial_in <= 1'b1;
		repeat (2 * BIT) @(posedge aclk);
	endtask
	// Returns once the line falls again or stop_len reaches 48, so a following frame is caught at its start.
	task automatic recv(input int n, input logic pe, output logic [7:0] d, output logic pb,
		output int stop_len);
		int k;
		d = 8'h00;
		pb = 1'b0;
		stop_len = BIT / 2;
		k = 0;
		while (serial_out !== 1'b0 && k < 4000) begin
			tick(1);
			k++;
		end
		tick(BIT / 2);
		for (int i = 0; i < n; i++) begin
			tick(BIT);
			d[i] = serial_out;
		end
		if (pe) begin
			tick(BIT);
			pb = serial_out;
		end
		tick(BIT);
		while (serial_out === 1'b1 && stop_len < 48) begin
			tick(1);
			stop_len++;
		end
	endtask
endmodule

//--- bench/tb_async_receiver_transmitter.sv
// Self-checking bench for the receiver/transmitter over its register bus.
// Assumes the divisor starts at 0, giving a tick every aclk cycle.
module tb_async_receiver_transmitter;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, serial_in, serial_out;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          fail_count = 0;
	int          checks_done = 0;
	int          cyc = 0;
	aur_uart #(.DIV_INIT(16'h0000)) i_aur_uart (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .serial_in, .serial_out);
	aur_remote_model i_aur_remote_model (.aclk, .serial_in, .serial_out);
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (fail_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ah, wh, bh;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(negedge aclk);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bh = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
			if (bh) begin
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ah, rh;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(negedge aclk);
			ah = s_axi_arvalid && s_axi_arready;
			rh = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ah) s_axi_arvalid <= 1'b0;
			if (rh) begin
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask
	function automatic logic par(input logic [7:0] d, input logic [4:0] c);
		return c[4] ? ^d : ~^d;
	endfunction
	task automatic t_reset_values();
		logic [31:0] v;
		logic [1:0] r;
		rd(aur_pkg::ADDR_STATUS, v, r);
		chk("status after reset", 32'h0000_0030, v);
		chk("line after reset", 32'h0000_0001, {31'h0, serial_out});
		rd(8'h20, v, r);
		chk("unmapped read resp", {30'h0, aur_pkg::RESP_SLVERR}, {30'h0, r});
		wr(8'h20, 32'h0000_0001, r);
		chk("unmapped write resp", {30'h0, aur_pkg::RESP_SLVERR}, {30'h0, r});
		wr(aur_pkg::ADDR_CTRL, 32'hFFFF_FFFF, r);
		rd(aur_pkg::ADDR_CTRL, v, r);
		chk("ctrl upper bits", 32'h0000_001F, v);
		wr(aur_pkg::ADDR_DIV, 32'h0000_0001, r);
		rd(aur_pkg::ADDR_DIV, v, r);
		chk("divisor", 32'h0000_0001, v);
		wr(aur_pkg::ADDR_DIV, 32'h0000_0000, r);
	endtask
	task automatic t_tx(input logic [4:0] c);
		logic [7:0] d0, g0, g1, m;
		logic p0, p1;
		int n, s0, s1, hs;
		logic [31:0] st;
		logic [1:0] r;
		n = 5 + int'(c[1:0]);
		m = 8'hFF >> (8 - n);
		d0 = (8'hA5 ^ {3'h0, c}) & m;
		hs = c[2] ? ((n == 5) ? 3 : 4) : 2;
		wr(aur_pkg::ADDR_CTRL, {27'h0, c}, r);
		fork
			begin
				i_aur_remote_model.recv(n, !c[3], g0, p0, s0);
				i_aur_remote_model.recv(n, !c[3], g1, p1, s1);
			end
			begin
				wr(aur_pkg::ADDR_TXDATA, {24'h0, d0}, r);
				wr(aur_pkg::ADDR_TXDATA, {24'h0, ~d0 & m}, r);
				rd(aur_pkg::ADDR_STATUS, st, r);
				chk("holding empty and eoc busy", 32'h0, {30'h0, st[5:4]});
			end
		join
		chk("tx first char", {24'h0, d0}, {24'h0, g0});
		chk("tx second char", {24'h0, ~d0 & m}, {24'h0, g1});
		if (!c[3]) chk("tx parity", {31'h0, par(d0, c)}, {31'h0, p0});
		chk("stop time", 32'(hs * 8), 32'((s0 >= hs * 8 && s0 <= hs * 8 + 2) ? hs * 8 : s0));
		rd(aur_pkg::ADDR_STATUS, st, r);
		chk("end of char", 32'h3, {30'h0, st[5:4]});
	endtask
	task automatic t_rx(input logic [4:0] c);
		logic [7:0] d, m;
		int n;
		logic [31:0] v;
		logic [1:0] r;
		n = 5 + int'(c[1:0]);
		m = 8'hFF >> (8 - n);
		d = (8'h3C ^ {3'h0, c}) & m;
		wr(aur_pkg::ADDR_CTRL, {27'h0, c}, r);
		i_aur_remote_model.send(d, n, !c[3], par(d, c), c[2] ? ((n == 5) ? 3 : 4) : 2, 1'b1);
		rd(aur_pkg::ADDR_RXDATA, v, r);
		chk("rx char", {24'h0, d}, v);
		rd(aur_pkg::ADDR_STATUS, v, r);
		chk("rx flags", 32'h1, {28'h0, v[3:0]});
		wr(aur_pkg::ADDR_STATUS, 32'h0000_0001, r);
		rd(aur_pkg::ADDR_STATUS, v, r);
		chk("available cleared", 32'h0, {31'h0, v[0]});
	endtask
	task automatic t_rx_errors();
		logic [31:0] v;
		logic [1:0] r;
		wr(aur_pkg::ADDR_CTRL, 32'h0000_0003, r);
		i_aur_remote_model.send(8'h55, 8, 1'b1, 1'b0, 2, 1'b1);
		rd(aur_pkg::ADDR_STATUS, v, r);
		chk("parity error", 32'h3, {28'h0, v[3:0]});
		i_aur_remote_model.send(8'h96, 8, 1'b1, 1'b1, 2, 1'b0);
		i_aur_remote_model.send(8'h17, 8, 1'b1, 1'b1, 2, 1'b1);
		rd(aur_pkg::ADDR_STATUS, v, r);
		chk("overrun kept char", 32'h9, {28'h0, v[3:0]});
		rd(aur_pkg::ADDR_RXDATA, v, r);
		chk("newest char", 32'h0000_0017, v);
		wr(aur_pkg::ADDR_STATUS, 32'h0000_0001, r);
		i_aur_remote_model.send(8'h96, 8, 1'b1, 1'b1, 2, 1'b0);
		rd(aur_pkg::ADDR_STATUS, v, r);
		chk("framing error", 32'h5, {28'h0, v[3:0]});
		wr(aur_pkg::ADDR_STATUS, 32'h0000_0001, r);
		wr(aur_pkg::ADDR_CTRL, 32'h0000_000B, r);
		i_aur_remote_model.send(8'hF0, 8, 1'b0, 1'b0, 2, 1'b1);
		rd(aur_pkg::ADDR_STATUS, v, r);
		chk("no parity flags", 32'h1, {28'h0, v[3:0]});
	endtask
	task automatic t_false_start();
		logic [31:0] v;
		logic [1:0] r;
		wr(aur_pkg::ADDR_STATUS, 32'h0000_0001, r);
		wr(aur_pkg::ADDR_CTRL, 32'h0000_0003, r);
		i_aur_remote_model.glitch(4);
		rd(aur_pkg::ADDR_STATUS, v, r);
		chk("glitch ignored", 32'h0, {31'h0, v[0]});
		i_aur_remote_model.send(8'h81, 8, 1'b1, 1'b1, 2, 1'b1);
		rd(aur_pkg::ADDR_RXDATA, v, r);
		chk("char after glitch", 32'h0000_0081, v);
		wr(aur_pkg::ADDR_STATUS, 32'h0000_0002, r);
		rd(aur_pkg::ADDR_STATUS, v, r);
		chk("status after ext reset", 32'h0000_0030, v);
		rd(aur_pkg::ADDR_CTRL, v, r);
		chk("ctrl kept", 32'h0000_0003, v);
	endtask
	initial begin
		aresetn = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset_values();
		for (int c = 0; c < 32; c++) begin
			t_tx(5'(c));
			t_rx(5'(c));
		end
		t_rx_errors();
		t_false_start();
		report_and_stop();
	end
endmodule
bind aur_uart aur_props i_aur_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .serial_out);
